// ---- trap_pkg.sv ----
// How it works
// - Trace after return_and_suppress_trace waits one instruction
// - Trace after return_from_interrupt taken immediately
// - Trace trap serviced before pending device interrupt
// - Only implicit status loads change trace_flag
// - Console status access cannot change trace_flag
// - Stack pointer bus error gives fatal trap
// - Bus error in trap service rebuilds stack low
// - Higher interrupt preempts routine's first instruction
// - Power fail deferred until bus reset completes
package trap_pkg;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam int        NUM_IRQ        = 4;       // Request lines
  localparam logic [2:0] IRQ_LEVEL_BASE = 3'h4;   // Level of line 0
  localparam logic [2:0] RESET_PRIO     = 3'h0;   // Priority after reset
  localparam logic      RESET_TRACE    = 1'b0;    // Trace flag after reset
  localparam logic [15:0] STACK_PC_ADDR = 16'h0000; // Fresh stack, PC slot
  localparam logic [15:0] STACK_PS_ADDR = 16'h0002; // Fresh stack, PS slot
  localparam int        SYNC_STAGES    = 2;       // Pin synchroniser depth

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Status bits this block owns
  typedef struct packed {
    logic [2:0] prio;   // Processor priority
    logic       trace;  // Trace flag
  } psw_t;

  // Instruction completion report
  typedef struct packed {
    logic done;    // Instruction finished this cycle
    logic isRti;   // It was return_from_interrupt
    logic isRtt;   // It was return_and_suppress_trace
    psw_t loaded;  // Status popped by a return
  } instr_t;

  // Explicit status write
  typedef struct packed {
    logic valid;    // Write strobe
    logic console;  // Access from console mode
    psw_t data;     // Written value
  } pswWrite_t;

  // Service kinds, one-hot
  typedef enum logic [4:0] {
    KIND_NONE  = 5'b00001,
    KIND_FATAL = 5'b00010,
    KIND_TRACE = 5'b00100,
    KIND_PWRF  = 5'b01000,
    KIND_INTR  = 5'b10000
  } kind_t;

  // Service request to the sequencer
  typedef struct packed {
    kind_t      kind;      // What to enter
    logic [1:0] irqIdx;    // Granted request line
    logic       newStack;  // Rebuild stack at low memory
  } svc_t;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_RUN     = 3'b001,
    ST_DECIDE  = 3'b010,
    ST_SERVICE = 3'b100
  } state_t;

  // Whole state of the sequencer
  typedef struct packed {
    state_t state;    // Control state
    psw_t   psw;      // Priority and trace flag
    svc_t   svc;      // Current request
    logic   pfTaken;  // Power fail already serviced
  } seqState_t;

endpackage : trap_pkg

// ---- input_sync.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Two-stage synchroniser for asynchronous pins
// ------------------------------------------------------------------
module input_sync
  import trap_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // All stages in one word
  typedef struct packed {
    logic [W-1:0] stage2;  // Read by logic
    logic [W-1:0] stage1;  // Read only by stage2
  } syncState_t;

  syncState_t cur;   // Registered state
  syncState_t next_cur;  // Next state

  // Shift chain
  always_comb begin
    next_cur        = cur;
    next_cur.stage1 = d;
    next_cur.stage2 = cur.stage1;
  end

  // Register, frozen while ce low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  assign q = cur.stage2;

endmodule : input_sync

// ---- trace_trap_sequencer.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Trap and interrupt sequencing
// ------------------------------------------------------------------
module trace_trap_sequencer
  import trap_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire instr_t             instr,
  input  wire pswWrite_t          pswWrite,
  input  wire logic               stackErr,
  input  wire logic               busErr,
  input  wire logic               resetActive,
  input  wire logic               svcAck,
  input  wire psw_t               entryPsw,
  input  wire logic [NUM_IRQ-1:0] irqPin,
  input  wire logic               powerFailPin,
  output logic                    runOk,
  output svc_t                    svc,
  output logic                    traceFlag,
  output logic [2:0]              prio,
  output logic [15:0]             stackPcAddr,
  output logic [15:0]             stackPsAddr
);

  // ----------------------------------------------------------------
  // Synchronised pins
  // ----------------------------------------------------------------
  logic [NUM_IRQ-1:0] irqSync;  // Request levels
  logic               pfSync;   // Power fail level

  input_sync #(.W(NUM_IRQ + 1)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({powerFailPin, irqPin}),
    .q     ({pfSync, irqSync})
  );

  seqState_t cur;       // Registered state
  seqState_t next_cur;  // Next state

  // ----------------------------------------------------------------
  // Highest request line above a priority
  // ----------------------------------------------------------------
  function automatic logic [2:0] irqAbove(input logic [NUM_IRQ-1:0] req,
                                           input logic [2:0] level);
    logic [2:0] hit;
    hit = 3'h0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (req[i] && (IRQ_LEVEL_BASE + 3'(i) > level)) begin
        hit = {1'b1, 2'(i)};
      end
    end
    return hit;
  endfunction : irqAbove

  // ----------------------------------------------------------------
  // Choose the next service at a boundary
  // ----------------------------------------------------------------
  function automatic svc_t pick(input logic pf, input logic [2:0] hit);
    svc_t s;
    s          = '{kind: KIND_NONE, irqIdx: 2'h0, newStack: 1'b0};
    if (pf) begin
      s.kind = KIND_PWRF;
    end else if (hit[2]) begin
      s.kind   = KIND_INTR;
      s.irqIdx = hit[1:0];
    end
    return s;
  endfunction : pick

  logic       pfReady;   // Power fail may be recognised
  logic [2:0] hitNow;    // Interrupt above current priority
  logic       traceNow;  // Trace trap due at this boundary

  assign pfReady = pfSync && !cur.pfTaken && !resetActive;
  assign hitNow  = irqAbove(irqSync, cur.psw.prio);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    traceNow = 1'b0;
    // Power fail dropped: allow a later one
    if (!pfSync) begin
      next_cur.pfTaken = 1'b0;
    end
    case (cur.state)
      ST_RUN: begin
        // Explicit or console write keeps trace flag
        if (pswWrite.valid) begin
          next_cur.psw.prio = pswWrite.data.prio;
        end
        if (stackErr) begin
          // Stack reference fault, no halt
          next_cur.svc   = '{kind: KIND_FATAL, irqIdx: 2'h0,
                             newStack: 1'b0};
          next_cur.state = ST_SERVICE;
        end else if (instr.done) begin
          if (instr.isRti) begin
            traceNow      = instr.loaded.trace;
            next_cur.psw  = instr.loaded;
          end else if (instr.isRtt) begin
            traceNow      = 1'b0;
            next_cur.psw  = instr.loaded;
          end else begin
            traceNow      = cur.psw.trace;
          end
          if (traceNow) begin
            // Trace ahead of any interrupt
            next_cur.svc   = '{kind: KIND_TRACE, irqIdx: 2'h0,
                               newStack: 1'b0};
            next_cur.state = ST_SERVICE;
          end else begin
            next_cur.svc = pick(pfReady,
                                irqAbove(irqSync, next_cur.psw.prio));
            if (next_cur.svc.kind != KIND_NONE) begin
              next_cur.state = ST_SERVICE;
            end
          end
        end
      end
      ST_SERVICE: begin
        if (busErr) begin
          // Error during entry: fresh stack low
          next_cur.svc.kind     = KIND_FATAL;
          next_cur.svc.newStack = 1'b1;
        end else if (svcAck) begin
          next_cur.psw   = entryPsw;
          if (cur.svc.kind == KIND_PWRF) begin
            next_cur.pfTaken = 1'b1;
          end
          next_cur.svc   = '{kind: KIND_NONE, irqIdx: 2'h0,
                             newStack: 1'b0};
          next_cur.state = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        // Check again before routine's first instruction
        next_cur.svc = pick(pfReady, hitNow);
        if (next_cur.svc.kind != KIND_NONE) begin
          next_cur.state = ST_SERVICE;
        end else begin
          next_cur.state = ST_RUN;
        end
      end
      default: begin
        next_cur.state = ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register, frozen while ce low
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur.state   <= ST_RUN;
      cur.psw     <= '{prio: RESET_PRIO, trace: RESET_TRACE};
      cur.svc     <= '{kind: KIND_NONE, irqIdx: 2'h0, newStack: 1'b0};
      cur.pfTaken <= 1'b0;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign runOk       = (cur.state == ST_RUN);
  assign svc         = cur.svc;
  assign traceFlag   = cur.psw.trace;
  assign prio        = cur.psw.prio;
  assign stackPcAddr = STACK_PC_ADDR;
  assign stackPsAddr = STACK_PS_ADDR;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_rtt_defer;
    @(posedge clk) disable iff (!rst_n)
      ce && runOk && !stackErr && instr.done && instr.isRtt
      |=> svc.kind != KIND_TRACE;
  endproperty
  a_rtt_defer: assert property (p_rtt_defer)
    else $error("trace taken right after suppressing return");

  property p_trace_next;
    @(posedge clk) disable iff (!rst_n)
      ce && runOk && !stackErr && instr.done && !instr.isRti &&
      !instr.isRtt && traceFlag
      |=> svc.kind == KIND_TRACE && !runOk;
  endproperty
  a_trace_next: assert property (p_trace_next)
    else $error("trace not taken after traced instruction");

  property p_rti_trace;
    @(posedge clk) disable iff (!rst_n)
      ce && runOk && !stackErr && instr.done && instr.isRti &&
      instr.loaded.trace
      |=> svc.kind == KIND_TRACE;
  endproperty
  a_rti_trace: assert property (p_rti_trace)
    else $error("trace not immediate after interrupt return");

  property p_trace_first;
    @(posedge clk) disable iff (!rst_n)
      ce && runOk && !stackErr && instr.done && !instr.isRtt &&
      !instr.isRti && traceFlag && (|irqSync)
      |=> svc.kind != KIND_INTR;
  endproperty
  a_trace_first: assert property (p_trace_first)
    else $error("interrupt ahead of trace trap");

  property p_write_keeps;
    @(posedge clk) disable iff (!rst_n)
      ce && runOk && pswWrite.valid && !pswWrite.console &&
      !instr.done
      |=> traceFlag == $past(traceFlag);
  endproperty
  a_write_keeps: assert property (p_write_keeps)
    else $error("explicit write changed trace flag");

  property p_console_keeps;
    @(posedge clk) disable iff (!rst_n)
      ce && runOk && pswWrite.valid && pswWrite.console &&
      !instr.done
      |=> $stable(traceFlag);
  endproperty
  a_console_keeps: assert property (p_console_keeps)
    else $error("console changed trace flag");

  property p_stack_fatal;
    @(posedge clk) disable iff (!rst_n)
      ce && runOk && stackErr
      |=> svc.kind == KIND_FATAL && !runOk;
  endproperty
  a_stack_fatal: assert property (p_stack_fatal)
    else $error("stack fault not fatal trap");

  property p_new_stack;
    @(posedge clk) disable iff (!rst_n)
      ce && cur.state == ST_SERVICE && busErr
      |=> svc.newStack && svc.kind == KIND_FATAL &&
          stackPcAddr == 16'h0000;
  endproperty
  a_new_stack: assert property (p_new_stack)
    else $error("no fresh stack after bus error in service");

  property p_preempt;
    @(posedge clk) disable iff (!rst_n)
      ce && cur.state == ST_DECIDE && hitNow[2] && !pfReady
      |=> svc.kind == KIND_INTR && !runOk;
  endproperty
  a_preempt: assert property (p_preempt)
    else $error("first routine instruction ran before higher request");

  property p_pf_defer;
    @(posedge clk) disable iff (!rst_n)
      ce && resetActive && cur.state != ST_SERVICE
      |=> svc.kind != KIND_PWRF;
  endproperty
  a_pf_defer: assert property (p_pf_defer)
    else $error("power fail recognised during bus reset");

endmodule : trace_trap_sequencer

// ---- service_responder.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Entry sequencer model: acknowledges each service after a delay
// ------------------------------------------------------------------
module service_responder
  import trap_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire svc_t       svc,      // Request from the block
  input  wire logic [3:0] delay,    // Cycles before the ack
  input  wire psw_t       trapPsw,  // Status loaded on trap entry
  output logic            svcAck,   // One-cycle ack
  output psw_t            entryPsw  // New status with the ack
);
  logic [3:0] cnt;  // Wait counter

  // Count, ack once; status bus garbled outside the ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= 4'h0;
      svcAck   <= 1'b0;
      entryPsw <= '0;
    end else if (svcAck) begin
      svcAck   <= 1'b0;
      cnt      <= 4'h0;
      entryPsw <= ~entryPsw;
    end else if (svc.kind != KIND_NONE && cnt == delay) begin
      svcAck   <= 1'b1;
      // Interrupt entry takes the line's level, traps take trapPsw
      entryPsw <= (svc.kind == KIND_INTR) ?
                  {IRQ_LEVEL_BASE + {1'b0, svc.irqIdx}, 1'b0} : trapPsw;
    end else begin
      cnt <= (svc.kind != KIND_NONE) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : service_responder

// ---- testbench.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Self-checking bench for the trap sequencer
// ------------------------------------------------------------------
module testbench
  import trap_pkg::*;
;
  logic               clk, rst_n, ce, stackErr, busErr, resetActive;
  logic               powerFailPin, svcAck, runOk, traceFlag;
  instr_t             instr;        // Completion report
  pswWrite_t          pswWrite;     // Explicit status write
  logic [NUM_IRQ-1:0] irqPin;       // Device request lines
  psw_t               entryPsw;     // From the model
  psw_t               trapPsw;      // Trap entry status
  logic [3:0]         delay;        // Model ack delay
  svc_t               svc;          // Service request
  logic [2:0]         prio;         // Current priority
  logic [15:0]        stackPcAddr, stackPsAddr;
  int                 numErrors, checks;

  trace_trap_sequencer trace_trap_sequencer_inst (
    .clk(clk), .rst_n(rst_n), .ce(ce), .instr(instr),
    .pswWrite(pswWrite), .stackErr(stackErr), .busErr(busErr),
    .resetActive(resetActive), .svcAck(svcAck), .entryPsw(entryPsw),
    .irqPin(irqPin), .powerFailPin(powerFailPin), .runOk(runOk),
    .svc(svc), .traceFlag(traceFlag), .prio(prio),
    .stackPcAddr(stackPcAddr), .stackPsAddr(stackPsAddr));

  service_responder service_responder_inst (
    .clk(clk), .rst_n(rst_n), .svc(svc), .delay(delay),
    .trapPsw(trapPsw), .svcAck(svcAck), .entryPsw(entryPsw));

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, got);
    checks++;
    if (got !== exp) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic give_verdict;
    $display("Counts: %0d compares, %0d mismatches", checks, numErrors);
    if (numErrors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // Bounded wait for run state or for a service kind
  task automatic waitFor(input logic run, input kind_t k);
    int n;
    n = 0;
    while (!(run ? runOk === 1'b1 : svc.kind === k)) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 20) begin
        numErrors++;
        $display("CHECK FAILED wait expected %h seen %h", k, svc.kind);
        give_verdict;
      end
    end
    checks++;
  endtask : waitFor

  // One instruction completion, sampled after the taking edge
  task automatic doInstr(input logic return_from_interrupt, return_and_suppress_trace, input psw_t ld);
    waitFor(1'b1, KIND_NONE);
    @(posedge clk);
    instr <= '{done: 1'b1, isRti: return_from_interrupt, isRtt: return_and_suppress_trace, loaded: ld};
    @(posedge clk);
    instr <= '0;
    #1;
  endtask : doInstr

  task automatic writePsw(input logic con, input psw_t d);
    @(posedge clk);
    pswWrite <= '{valid: 1'b1, console: con, data: d};
    @(posedge clk);
    pswWrite <= '0;
    #1;
  endtask : writePsw

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testReset;
    check("traceFlag", 16'h0000, traceFlag);
    check("prio", 16'h0000, prio);
    check("runOk", 16'h0001, runOk);
    check("svc.kind", KIND_NONE, svc.kind);
    check("stackPcAddr", 16'h0000, stackPcAddr);
    check("stackPsAddr", 16'h0002, stackPsAddr);
    $display("reset test done");
  endtask : testReset

  task automatic testWrite;
    writePsw(1'b0, {3'h3, 1'b1});
    check("traceFlag", 16'h0000, traceFlag);
    check("prio", 16'h0003, prio);
    writePsw(1'b1, {3'h0, 1'b1});
    check("traceFlag", 16'h0000, traceFlag);
    // Write while clock enable is low must be lost
    @(posedge clk);
    ce <= 1'b0;
    writePsw(1'b0, {3'h7, 1'b0});
    check("prio", 16'h0000, prio);
    @(posedge clk);
    ce <= 1'b1;
    writePsw(1'b0, {3'h0, 1'b0});
    $display("status write test done");
  endtask : testWrite

  task automatic testRti;
    doInstr(1'b1, 1'b0, {3'h0, 1'b1});
    check("svc.kind", KIND_TRACE, svc.kind);
    waitFor(1'b1, KIND_NONE);
    check("traceFlag", 16'h0000, traceFlag);
    $display("return trace test done");
  endtask : testRti

  // Deferred trace, trace before interrupt, then preemption
  task automatic testTraceIrq;
    @(posedge clk);
    delay <= 4'h4;
    doInstr(1'b0, 1'b1, {3'h0, 1'b1});
    check("svc.kind", KIND_NONE, svc.kind);
    check("traceFlag", 16'h0001, traceFlag);
    // Neither path may clear a set trace flag
    writePsw(1'b0, {3'h0, 1'b0});
    check("traceFlag", 16'h0001, traceFlag);
    writePsw(1'b1, {3'h0, 1'b0});
    check("traceFlag", 16'h0001, traceFlag);
    irqPin <= 4'h1;
    repeat (3) @(posedge clk);
    doInstr(1'b0, 1'b0, '0);
    check("svc.kind", KIND_TRACE, svc.kind);
    waitFor(1'b0, KIND_INTR);
    check("svc.irqIdx", 16'h0000, svc.irqIdx);
    irqPin <= 4'h3;
    waitFor(1'b0, KIND_NONE);
    waitFor(1'b0, KIND_INTR);
    check("svc.irqIdx", 16'h0001, svc.irqIdx);
    check("runOk", 16'h0000, runOk);
    irqPin <= 4'h0;
    waitFor(1'b1, KIND_NONE);
    check("prio", 16'h0005, prio);
    writePsw(1'b0, {3'h0, 1'b0});
    $display("trace and interrupt test done");
  endtask : testTraceIrq

  task automatic testFatal;
    waitFor(1'b1, KIND_NONE);
    @(posedge clk);
    stackErr <= 1'b1;
    @(posedge clk);
    stackErr <= 1'b0;
    #1;
    check("svc.kind", KIND_FATAL, svc.kind);
    @(posedge clk);
    busErr <= 1'b1;
    @(posedge clk);
    busErr <= 1'b0;
    #1;
    check("svc.newStack", 16'h0001, svc.newStack);
    check("svc.kind", KIND_FATAL, svc.kind);
    waitFor(1'b1, KIND_NONE);
    check("svc.kind", KIND_NONE, svc.kind);
    $display("fatal trap test done");
  endtask : testFatal

  task automatic testPower;
    @(posedge clk);
    resetActive  <= 1'b1;
    powerFailPin <= 1'b1;
    repeat (3) @(posedge clk);
    // Boundary while bus reset still active: no power fail yet
    doInstr(1'b0, 1'b0, '0);
    check("svc.kind", KIND_NONE, svc.kind);
    check("runOk", 16'h0001, runOk);
    @(posedge clk);
    resetActive <= 1'b0;
    instr       <= '{done: 1'b1, isRti: 1'b0, isRtt: 1'b0, loaded: '0};
    @(posedge clk);
    instr <= '0;
    #1;
    waitFor(1'b0, KIND_PWRF);
    powerFailPin <= 1'b0;
    waitFor(1'b1, KIND_NONE);
    $display("power fail test done");
  endtask : testPower

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n        = 1'b0;
    ce           = 1'b1;
    instr        = '0;
    pswWrite     = '0;
    stackErr     = 1'b0;
    busErr       = 1'b0;
    resetActive  = 1'b0;
    irqPin       = '0;
    powerFailPin = 1'b0;
    delay        = 4'h0;
    trapPsw      = '0;
    numErrors    = 0;
    checks       = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    testReset;
    testWrite;
    testRti;
    testTraceIrq;
    testFatal;
    testPower;
    give_verdict;
  end
endmodule : testbench
